// ---- tb/res_proc_model.sv ----
// Processor-side model: enable pins, mode pin and long watchdog starvation
`timescale 1ns/1ps
module res_proc_model (
  input wire logic clk_in, // Clock
  input wire logic [2:0] req_en_in, // Channels wanted on
  input wire logic req_mode_in, // Forced PWM wanted
  input wire logic starve_in, // Stop refreshing the long watchdog
  output logic buck_en_out, // First enable pin
  output logic lin_a_en_out, // Second enable pin
  output logic lin_b_en_out, // Third enable pin
  output logic mode_out, // Mode pin
  output logic long_out // Expired long watchdog
);
  initial begin
    {buck_en_out, lin_a_en_out, lin_b_en_out, mode_out, long_out} = 5'h00;
  end
  // Pins move just after the edge, as firmware writing a port would
  always @(posedge clk_in) begin
    buck_en_out <= req_en_in[0];
    lin_a_en_out <= req_en_in[1];
    lin_b_en_out <= req_en_in[2];
    mode_out <= req_mode_in;
    long_out <= starve_in;
  end
endmodule // res_proc_model

// ---- tb/res_top_props.sv ----
// Port-level assertions for the regulator enable sequencer
`timescale 1ns/1ps
module res_top_props (
  input wire logic clk_in, // Clock
  input wire logic rst_n_in, // Reset, active low
  input wire logic buck_enable_in, // Buck request
  input wire logic linear_a_enable_in, // Linear A request
  input wire logic buck_mode_sel_in, // Mode select
  input wire logic light_load_in, // Light load flag
  input wire logic over_temp_in, // Over-temperature
  input wire logic uvlo_in, // Undervoltage
  input wire logic long_timeout_in, // Long watchdog expiry
  input wire logic psel_in, // APB select
  input wire logic penable_in, // APB enable
  input wire logic pready_out, // APB ready
  input wire logic pslverr_out, // APB error
  input wire logic buck_run_out, // Buck run
  input wire logic linear_reg_a_run_out, // Linear A run
  input wire logic linear_reg_b_run_out, // Linear B run
  input wire logic buck_soft_start_out, // Buck soft start
  input wire logic buck_pwm_out, // Buck PWM
  input wire logic buck_psm_out, // Buck power save
  input wire logic buck_switches_off_out, // Buck switches off
  input wire logic watchdog_cause_out // Reset cause
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic any_run = buck_run_out | linear_reg_a_run_out | linear_reg_b_run_out;
  AST_SS_ON: assert property ($rose(buck_run_out) |-> buck_soft_start_out)
    else $error("buck started without soft start");
  AST_SS_ONLY: assert property (buck_soft_start_out |-> $rose(buck_run_out))
    else $error("soft start without buck turn-on");
  AST_EN_BUCK: assert property (buck_run_out |-> $past(buck_enable_in, 3))
    else $error("buck runs without its enable");
  AST_EN_LA: assert property (linear_reg_a_run_out |-> $past(linear_a_enable_in, 3))
    else $error("linear A runs without its enable");
  AST_UVLO: assert property (uvlo_in [*3] |=> !any_run && buck_switches_off_out)
    else $error("channel alive in undervoltage");
  AST_HOT: assert property (over_temp_in [*4] |=> !any_run)
    else $error("channel alive while too hot");
  AST_PWM: assert property ((buck_mode_sel_in && buck_run_out) [*4] |-> buck_pwm_out && !buck_psm_out)
    else $error("forced PWM not held");
  AST_PSM: assert property ((!buck_mode_sel_in && light_load_in && buck_run_out) [*4] |->
    buck_psm_out && !buck_pwm_out)
    else $error("power save not entered at light load");
  AST_CAUSE: assert property ($rose(long_timeout_in) |-> ##[2:4] !watchdog_cause_out)
    else $error("long event not shown as cause");
  AST_APB_RDY: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready after setup");
  AST_APB_ERR: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  COV_LONG: cover property ($rose(long_timeout_in));
  COV_SS: cover property (buck_soft_start_out);
  COV_PSM: cover property (buck_psm_out);
  COV_ERR: cover property (pslverr_out);
endmodule // res_top_props

bind res_top res_top_props i_props (.clk_in, .rst_n_in, .buck_enable_in, .linear_a_enable_in,
  .buck_mode_sel_in, .light_load_in, .over_temp_in, .uvlo_in, .long_timeout_in, .psel_in, .penable_in,
  .pready_out, .pslverr_out, .buck_run_out, .linear_reg_a_run_out, .linear_reg_b_run_out,
  .buck_soft_start_out, .buck_pwm_out, .buck_psm_out, .buck_switches_off_out, .watchdog_cause_out);

// ---- tb/tb_top.sv ----
// Self-checking bench for the regulator enable sequencer
`timescale 1ns/1ps
module tb_top;
  import res_pkg::*;
  localparam int TDIV = 4;
  localparam int STK = 2;
  typedef struct {logic [2:0] ss; bit timed;} res_note_t;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [2:0] req_en = 3'h0;
  logic req_mode = 1'b0, starve = 1'b0, light = 1'b0, hot = 1'b0, cool = 1'b1, uv = 1'b0, shrt = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, pwm, psm, swoff, uvsel, cause, irq, en_b, en_a, en_l, mode, lt;
  wire [2:0] run, ss;
  logic [2:0] ord [3][3] = '{'{3'h2, 3'h4, 3'h1}, '{3'h1, 3'h2, 3'h4}, '{3'h2, 3'h1, 3'h4}};
  int check_count = 0, miscompares = 0, cyc = 0, last = 0;
  res_note_t notes[$];
  res_note_t nt;

  always #5 clk_in = ~clk_in;

  res_proc_model i_proc (.clk_in(clk_in), .req_en_in(req_en), .req_mode_in(req_mode), .starve_in(starve),
    .buck_en_out(en_b), .lin_a_en_out(en_a), .lin_b_en_out(en_l), .mode_out(mode), .long_out(lt));

  res_top #(.TICK_DIV(TDIV), .STEP_TK(STK), .CAUSE_TK(5)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .buck_enable_in(en_b), .linear_a_enable_in(en_a), .linear_b_enable_in(en_l), .buck_mode_sel_in(mode),
    .light_load_in(light), .over_temp_in(hot), .temp_cool_in(cool), .uvlo_in(uv), .long_timeout_in(lt),
    .short_timeout_in(shrt), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .buck_run_out(run[0]), .linear_reg_a_run_out(run[1]), .linear_reg_b_run_out(run[2]),
    .buck_soft_start_out(ss[0]), .linear_reg_a_soft_start_out(ss[1]), .linear_reg_b_soft_start_out(ss[2]),
    .buck_pwm_out(pwm), .buck_psm_out(psm), .buck_switches_off_out(swoff), .uvlo_high_sel_out(uvsel),
    .watchdog_cause_out(cause), .irq_out(irq));

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      give_verdict();
    end
  endtask

  task automatic wait_drain();
    int n;
    n = 0;
    while (notes.size() != 0 && n < 200) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 200) begin
      miscompares++;
      give_verdict();
    end
  endtask

  // Every soft-start pulse must match the oldest expected turn-on
  always @(posedge clk_in) begin
    cyc++;
    if (rst_n_in === 1'b1 && ss !== 3'h0) begin
      if (notes.size() == 0) begin
        check(ss, 3'h0);
      end else begin
        nt = notes.pop_front();
        check(ss, nt.ss);
        if (nt.timed) check(cyc - last >= TDIV * STK && cyc - last <= TDIV * STK + 2, 1'b1);
        last = cyc;
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    give_verdict();
  end

  initial begin
    logic [31:0] rd;
    logic er;
    int k, s;
    void'($urandom(32'hE90AB2C6));
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    cycles(3);
    check({run, swoff, cause, irq, uvsel}, 7'h0C);
    for (k = 0; k < 3; k++) begin
      notes.push_back('{3'h1 << k, 1'b0});
      req_en <= 3'h1 << k;
      req_mode <= 1'($urandom);
      light <= 1'($urandom);
      cycles(6);
      check(run, 3'h1 << k);
    end
    $display("enable test done");
    notes.push_back('{3'h3, 1'b0});
    req_en <= 3'h7;
    for (k = 0; k < 4; k++) begin
      req_mode <= k[1];
      light <= k[0];
      cycles(6);
      check({pwm, psm}, {k[1] | !k[0], !k[1] & k[0]});
    end
    $display("mode test done");
    hot <= 1'b1;
    cool <= 1'b0;
    cycles(6);
    check({run, swoff}, 4'h1);
    hot <= 1'b0;
    cycles(8);
    check(run, 3'h0);
    notes.push_back('{3'h7, 1'b0});
    cool <= 1'b1;
    cycles(6);
    check(run, 3'h7);
    uv <= 1'b1;
    cycles(6);
    check({run, swoff}, 4'h1);
    notes.push_back('{3'h7, 1'b0});
    uv <= 1'b0;
    cycles(6);
    check(run, 3'h7);
    wait_drain();
    $display("fault test done");
    for (k = 0; k < 4; k++) begin
      // First pass leaves the override off, so the factory order is used
      apb(1'b1, ADDR_CTRL, (k == 0) ? 32'h0 : 32'(2 * k + 1), rd, er);
      if (k == 3) notes.push_back('{3'h7, 1'b0});
      else for (s = 0; s < 3; s++) notes.push_back('{ord[k][s], s > 0});
      starve <= 1'b1;
      cycles(8);
      check(cause, 1'b0);
      starve <= 1'b0;
      wait_drain();
      check(run, 3'h7);
    end
    cycles(40);
    check(cause, 1'b1);
    notes.push_back('{3'h7, 1'b0});
    starve <= 1'b1;
    cycles(8);
    starve <= 1'b0;
    shrt <= 1'b1;
    cycles(5);
    check(cause, 1'b1);
    shrt <= 1'b0;
    wait_drain();
    $display("sequencer test done");
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0, rd, er);
    check(rd, 32'hF);
    check(irq, 1'b0);
    apb(1'b1, ADDR_IRQ_EN, 32'hF, rd, er);
    cycles(2);
    check(irq, 1'b1);
    apb(1'b1, ADDR_IRQ_CLR, 32'hF, rd, er);
    cycles(2);
    check(irq, 1'b0);
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0, rd, er);
    check(rd, 32'h0);
    apb(1'b0, ADDR_CTRL, 32'h0, rd, er);
    check(rd, 32'h7);
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    check(rd, 32'h3C7);
    apb(1'b0, 8'h20, 32'h0, rd, er);
    check({er, rd}, 33'h100000000);
    $display("register test done");
    give_verdict();
  end
endmodule // tb_top

// ---- verilog/res_chan.sv ----
// One regulator channel gate with soft-start request
`timescale 1ns/1ps
module res_chan
  import res_pkg::*;
(
  input wire logic clk_in,  // System clock
  input wire logic rst_n_in,  // Synchronous reset, active low
  res_chan_if.chan bus  // Enable, permission, run and soft-start
);

  logic next_run;

  always_comb begin
    next_run = bus.enable & bus.permit;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bus.run <= 1'b0;
    end else begin
      bus.run <= next_run;
    end
  end

  // Every off-to-on turn, fault recovery included, ramps again
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bus.soft_start <= 1'b0;
    end else begin
      bus.soft_start <= next_run & ~bus.run;
    end
  end

endmodule // res_chan

// ---- verilog/res_chan_if.sv ----
// Carrier between the sequencer core and one channel gate
`timescale 1ns/1ps
interface res_chan_if;
  logic enable;
  logic permit;
  logic run;
  logic soft_start;
  modport ctl (output enable, output permit, input run, input soft_start);
  modport chan (input enable, input permit, output run, output soft_start);
endinterface

// ---- verilog/res_pkg.sv ----
// Constants, types and helpers shared by the regulator enable sequencer
package res_pkg;

  // Timing base
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int STEP_MS = 2;
  localparam int STEP_TICKS = (STEP_MS * 1000) / TICK_US;
  localparam int CAUSE_HOLD_S = 1;
  localparam int CAUSE_TICKS = (CAUSE_HOLD_S * 1_000_000) / TICK_US;

  // Undervoltage turn-off levels in mV, informative only
  localparam int UVLO_STD_MV = 2150;
  localparam int UVLO_HIGH_MV = 3650;

  // Channel indices
  localparam int NUM_CH = 3;
  localparam logic [1:0] CH_BUCK = 2'h0;
  localparam logic [1:0] CH_LIN_A = 2'h1;
  localparam logic [1:0] CH_LIN_B = 2'h2;

  // Restart order codes
  localparam logic [1:0] ORD_LA_LB_BUCK = 2'h0;
  localparam logic [1:0] ORD_BUCK_LA_LB = 2'h1;
  localparam logic [1:0] ORD_LA_BUCK_LB = 2'h2;
  localparam logic [1:0] ORD_ALL = 2'h3;
  localparam logic [1:0] LAST_SLOT = 2'h2;

  // Synchroniser lanes
  localparam int SYNC_W = 10;
  localparam int SI_EN_BUCK = 0;
  localparam int SI_EN_LA = 1;
  localparam int SI_EN_LB = 2;
  localparam int SI_MODE = 3;
  localparam int SI_LIGHT = 4;
  localparam int SI_HOT = 5;
  localparam int SI_COOL = 6;
  localparam int SI_UVLO = 7;
  localparam int SI_LONG = 8;
  localparam int SI_SHORT = 9;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;

  // Field positions
  localparam int CTRL_OVR_EN = 0;
  localparam int CTRL_ORD_LSB = 1;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  localparam int STAT_RUN_LSB = 0;
  localparam int STAT_THERM = 3;
  localparam int STAT_UVLO = 4;
  localparam int STAT_BUSY = 5;
  localparam int STAT_CAUSE = 6;
  localparam int STAT_PERM_LSB = 7;
  localparam int IRQ_THERMAL = 0;
  localparam int IRQ_UVLO = 1;
  localparam int IRQ_LONG_WD = 2;
  localparam int IRQ_SEQ_DONE = 3;
  localparam int IRQ_W = 4;
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

  typedef enum {SEQ_IDLE, SEQ_START, SEQ_WAIT} res_seq_t;

  // Channel started in a given slot of a restart order
  function automatic logic [1:0] res_slot_ch(input logic [1:0] order, input logic [1:0] slot);
    logic [1:0] ch;
    ch = CH_BUCK;
    case (order)
      ORD_LA_LB_BUCK: ch = (slot == 2'h0) ? CH_LIN_A : (slot == 2'h1) ? CH_LIN_B : CH_BUCK;
      ORD_BUCK_LA_LB: ch = (slot == 2'h0) ? CH_BUCK : (slot == 2'h1) ? CH_LIN_A : CH_LIN_B;
      ORD_LA_BUCK_LB: ch = (slot == 2'h0) ? CH_LIN_A : (slot == 2'h1) ? CH_BUCK : CH_LIN_B;
      default: ch = CH_BUCK;
    endcase
    return ch;
  endfunction

endpackage

// ---- verilog/res_top.sv ----
// Regulator enable sequencer: channel gating, faults, restart order, APB registers
//
// Functional notes
// - A channel runs only while its enable input is high.
// - Enable one drives buck, two drives linear A, three drives linear B.
// - Every off-to-on turn of a channel issues a soft-start request.
// - Mode select high forces fixed-frequency PWM on the buck.
// - Mode select low: PWM normally, burst power save at light load.
// - Over-temperature above 150 C switches all three channels off.
// - After thermal shutdown channels stay off until below 130 C.
// - Leaving thermal shutdown restarts enabled channels with soft start.
// - Undervoltage shuts all channels and both buck switches off.
// - Undervoltage clearing lets channels follow their enables again.
// - Undervoltage threshold choice is a fixed build parameter.
// - After long watchdog event channels restart in the selected order.
// - Restart steps are spaced 2 ms apart.
// - Order 00 A,B,buck; 01 buck,A,B; 10 A,buck,B; 11 all together.
// - A status output tells which watchdog caused the last reset.
// - Cause high after short timeout or power-on, low after long, clears in 1 s.
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
module res_top
  import res_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES,  // Clock cycles per timing tick
  parameter int STEP_TK = STEP_TICKS,  // Ticks between restart steps
  parameter int CAUSE_TK = CAUSE_TICKS,  // Ticks the long-event cause is held
  parameter logic [1:0] RESTART_ORDER = ORD_LA_LB_BUCK,  // Factory restart order
  parameter logic UVLO_HIGH = 1'b0  // Factory undervoltage level choice
) (
  input wire logic clk_in,  // 100 MHz system clock
  input wire logic rst_n_in,  // Synchronous reset, active low
  input wire logic buck_enable_in,  // Buck channel request
  input wire logic linear_a_enable_in,  // Linear A channel request
  input wire logic linear_b_enable_in,  // Linear B channel request
  input wire logic buck_mode_sel_in,  // High forces PWM
  input wire logic light_load_in,  // Buck load below power-save threshold
  input wire logic over_temp_in,  // Junction above 150 C
  input wire logic temp_cool_in,  // Junction below 130 C
  input wire logic uvlo_in,  // Supervisory supply undervoltage
  input wire logic long_timeout_in,  // Long watchdog expired, level
  input wire logic short_timeout_in,  // Short watchdog expired, level
  input wire logic psel_in,  // APB select
  input wire logic penable_in,  // APB enable
  input wire logic pwrite_in,  // APB direction
  input wire logic [7:0] paddr_in,  // APB byte address
  input wire logic [31:0] pwdata_in,  // APB write data
  output logic [31:0] prdata_out,  // APB read data
  output logic pready_out,  // APB ready
  output logic pslverr_out,  // APB error on unmapped address
  output logic buck_run_out,  // Buck run request
  output logic linear_reg_a_run_out,  // Linear A run request
  output logic linear_reg_b_run_out,  // Linear B run request
  output logic buck_soft_start_out,  // Buck soft-start pulse
  output logic linear_reg_a_soft_start_out,  // Linear A soft-start pulse
  output logic linear_reg_b_soft_start_out,  // Linear B soft-start pulse
  output logic buck_pwm_out,  // Buck in fixed-frequency PWM
  output logic buck_psm_out,  // Buck in burst power save
  output logic buck_switches_off_out,  // Power switch and rectifier both off
  output logic uvlo_high_sel_out,  // Selected undervoltage level
  output logic watchdog_cause_out,  // High short/power-on, low long event
  output logic irq_out  // Level interrupt
);

  // Input synchroniser, stage one read only by stage two
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] raw_in;
  logic long_prev;
  logic short_prev;
  logic uvlo_prev;
  logic long_ev;
  logic short_ev;
  logic hot_ev;
  logic uvlo_ev;

  // Timing, faults, sequencer
  logic [31:0] tick_cnt;
  logic tick;
  logic tick_clr;
  logic thermal;
  logic fault;
  res_seq_t seq_state;
  logic [NUM_CH-1:0] perm;
  logic [1:0] seq_ord;
  logic [1:0] slot;
  logic [31:0] step_cnt;
  logic seq_done;
  logic [31:0] cause_cnt;

  // Registers
  logic [CTRL_W-1:0] ctrl;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_en;
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_clr;
  logic [31:0] next_rdata;
  logic next_err;
  logic wr_en;
  logic [NUM_CH-1:0] run_vec;
  logic [NUM_CH-1:0] en_vec;
  logic [1:0] next_ord;

  assign raw_in = {short_timeout_in, long_timeout_in, uvlo_in, temp_cool_in, over_temp_in,
                   light_load_in, buck_mode_sel_in, linear_b_enable_in, linear_a_enable_in,
                   buck_enable_in};

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      long_prev <= 1'b0;
      short_prev <= 1'b0;
      uvlo_prev <= 1'b0;
    end else begin
      long_prev <= sync2[SI_LONG];
      short_prev <= sync2[SI_SHORT];
      uvlo_prev <= sync2[SI_UVLO];
    end
  end

  assign long_ev = sync2[SI_LONG] & ~long_prev;
  assign short_ev = sync2[SI_SHORT] & ~short_prev;
  assign uvlo_ev = sync2[SI_UVLO] & ~uvlo_prev;
  assign hot_ev = sync2[SI_HOT] & ~thermal;

  // Tick divider; restarted at each step so a gap is never short
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_clr) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == 32'(TICK_DIV - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick <= 1'b0;
    end
  end

  // Thermal latch with hysteresis
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      thermal <= 1'b0;
    end else if (sync2[SI_HOT]) begin
      thermal <= 1'b1;
    end else if (sync2[SI_COOL]) begin
      thermal <= 1'b0;
    end
  end

  assign fault = thermal | sync2[SI_UVLO];

  // Restart sequencer after a long watchdog event
  assign next_ord = ctrl[CTRL_OVR_EN] ? ctrl[CTRL_ORD_LSB +: 2] : RESTART_ORDER;
  assign tick_clr = (seq_state == SEQ_START);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      seq_state <= SEQ_IDLE;
      perm <= '1;
      seq_ord <= ORD_LA_LB_BUCK;
      slot <= 2'h0;
      step_cnt <= '0;
      seq_done <= 1'b0;
    end else if (long_ev) begin
      // A fresh event restarts the whole order, even mid-sequence
      seq_state <= SEQ_START;
      perm <= '0;
      seq_ord <= next_ord;
      slot <= 2'h0;
      step_cnt <= '0;
      seq_done <= 1'b0;
    end else begin
      seq_done <= 1'b0;
      case (seq_state)
        SEQ_IDLE: begin
          step_cnt <= '0;
        end
        SEQ_START: begin
          step_cnt <= '0;
          if (seq_ord == ORD_ALL) begin
            perm <= '1;
            seq_state <= SEQ_IDLE;
            seq_done <= 1'b1;
          end else begin
            perm[res_slot_ch(seq_ord, slot)] <= 1'b1;
            if (slot == LAST_SLOT) begin
              seq_state <= SEQ_IDLE;
              seq_done <= 1'b1;
            end else begin
              seq_state <= SEQ_WAIT;
            end
          end
        end
        SEQ_WAIT: begin
          if (tick) begin
            if (step_cnt == 32'(STEP_TK - 1)) begin
              slot <= slot + 2'h1;
              seq_state <= SEQ_START;
            end else begin
              step_cnt <= step_cnt + 32'h1;
            end
          end
        end
        default: begin
          seq_state <= SEQ_IDLE;
        end
      endcase
    end
  end

  // Channel gates
  res_chan_if ch_if[NUM_CH] ();
  assign en_vec = {sync2[SI_EN_LB], sync2[SI_EN_LA], sync2[SI_EN_BUCK]};

  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      assign ch_if[i].enable = en_vec[i];
      assign ch_if[i].permit = perm[i] & ~fault;
      assign run_vec[i] = ch_if[i].run;
      res_chan u_chan (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .bus(ch_if[i])
      );
    end
  endgenerate

  assign buck_run_out = ch_if[CH_BUCK].run;
  assign linear_reg_a_run_out = ch_if[CH_LIN_A].run;
  assign linear_reg_b_run_out = ch_if[CH_LIN_B].run;
  assign buck_soft_start_out = ch_if[CH_BUCK].soft_start;
  assign linear_reg_a_soft_start_out = ch_if[CH_LIN_A].soft_start;
  assign linear_reg_b_soft_start_out = ch_if[CH_LIN_B].soft_start;

  // Buck control mode, one cycle behind the run flop
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      buck_pwm_out <= 1'b0;
      buck_psm_out <= 1'b0;
      buck_switches_off_out <= 1'b1;
      uvlo_high_sel_out <= 1'b0;
    end else begin
      buck_pwm_out <= run_vec[CH_BUCK] & (sync2[SI_MODE] | ~sync2[SI_LIGHT]);
      buck_psm_out <= run_vec[CH_BUCK] & ~sync2[SI_MODE] & sync2[SI_LIGHT];
      buck_switches_off_out <= sync2[SI_UVLO] | ~run_vec[CH_BUCK];
      uvlo_high_sel_out <= UVLO_HIGH;
    end
  end

  // Watchdog cause; power-on leaves it high
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      watchdog_cause_out <= 1'b1;
      cause_cnt <= '0;
    end else if (long_ev) begin
      watchdog_cause_out <= 1'b0;
      cause_cnt <= '0;
    end else if (short_ev) begin
      watchdog_cause_out <= 1'b1;
      cause_cnt <= '0;
    end else if (!watchdog_cause_out && tick) begin
      if (cause_cnt == 32'(CAUSE_TK - 1)) begin
        watchdog_cause_out <= 1'b1;
        cause_cnt <= '0;
      end else begin
        cause_cnt <= cause_cnt + 32'h1;
      end
    end
  end

  // APB slave, one wait-free access phase
  assign wr_en = psel_in & penable_in & pready_out & pwrite_in;

  always_comb begin
    next_rdata = '0;
    next_err = 1'b0;
    case (paddr_in)
      ADDR_CTRL: next_rdata[CTRL_W-1:0] = ctrl;
      ADDR_STATUS: begin
        next_rdata[STAT_RUN_LSB +: NUM_CH] = run_vec;
        next_rdata[STAT_THERM] = thermal;
        next_rdata[STAT_UVLO] = sync2[SI_UVLO];
        next_rdata[STAT_BUSY] = (seq_state != SEQ_IDLE);
        next_rdata[STAT_CAUSE] = watchdog_cause_out;
        next_rdata[STAT_PERM_LSB +: NUM_CH] = perm;
      end
      ADDR_IRQ_STATUS: next_rdata[IRQ_W-1:0] = irq_status;
      ADDR_IRQ_EN: next_rdata[IRQ_W-1:0] = irq_en;
      ADDR_IRQ_CLR: next_rdata = '0;
      default: next_err = 1'b1;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
      prdata_out <= '0;
      pslverr_out <= 1'b0;
    end else if (psel_in && !penable_in && !pready_out) begin
      pready_out <= 1'b1;
      prdata_out <= pwrite_in ? 32'h0 : next_rdata;
      pslverr_out <= next_err;
    end else begin
      pready_out <= 1'b0;
      prdata_out <= '0;
      pslverr_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl <= CTRL_RST;
      irq_en <= IRQ_RST;
    end else if (wr_en) begin
      if (paddr_in == ADDR_CTRL) begin
        ctrl <= pwdata_in[CTRL_W-1:0];
      end
      if (paddr_in == ADDR_IRQ_EN) begin
        irq_en <= pwdata_in[IRQ_W-1:0];
      end
    end
  end

  // Sticky events; a set in the clearing cycle survives
  always_comb begin
    irq_ev = '0;
    irq_ev[IRQ_THERMAL] = hot_ev;
    irq_ev[IRQ_UVLO] = uvlo_ev;
    irq_ev[IRQ_LONG_WD] = long_ev;
    irq_ev[IRQ_SEQ_DONE] = seq_done;
    irq_clr = (wr_en && paddr_in == ADDR_IRQ_CLR) ? pwdata_in[IRQ_W-1:0] : IRQ_RST;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_status <= IRQ_RST;
      irq_out <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_ev;
      irq_out <= |(irq_status & irq_en);
    end
  end

endmodule // res_top
